// file: hw/wpc_watchdog_pll.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1: window and rate bits write once in user mode; debug-stop bit once.
// RULE2: in window mode a key write in first 75% resets the part.
// RULE3: in window mode first keys repeat harmlessly; second key restarts and closes window.
// RULE4: debug-stop set halts watchdog and periodic tick counters during active debug.
// RULE5: rate code 0 disables; 1..7 select 2^14..2^24 oscillator cycles.
// RULE6: writing a nonzero rate enables and starts the first period at once.
// RULE7: reaching the period end without service asserts system reset.
// RULE8: each period is measured from the last completed service restart.
// RULE9: factory registers read 0x00 and 0x80 and ignore writes outside special mode.
// RULE10: service key register reads zero; writes do nothing while rate is zero.
// RULE11: enabled watchdog resets at once on any key other than the two keys.
// RULE12: software writes first then second key; repeats and other accesses are harmless.
// RULE13: synth output is twice oscillator times (multiplier+1) over (divider+1).
// RULE14: with synth selected, bus clock is synth output divided by two.
// RULE15: tracking flag is clear during acquisition and set in tracking.
// RULE16: automatic mode switches filter itself; flags follow tolerance hysteresis.
// RULE17: with lock irq enabled, any lock flag change requests an interrupt.
// RULE18: manual mode software sequences acquire bit, waits, then selects synth.
// RULE19: software selects synth only while locked; lost lock is a disturbance.
// RULE20: first key arms; second key restarts only when armed and disarms.
module wpc_watchdog_pll
  import wpc_pkg::*;
#(
  parameter int RATE_LOG2_TRIM = 0  // subtracted from every timeout exponent, shortens simulation
) (
  input  wire logic                 sys_clk,          // oscillator clock
  input  wire logic                 rst_b,            // synchronous reset, active low
  input  wire logic [3:0]           regAddr,          // register index
  input  wire logic [7:0]           regWrData,        // write data
  input  wire logic                 regWrStb,         // write strobe
  input  wire logic                 regRdStb,         // read strobe
  output logic      [7:0]           regRdData,        // read data, cycle after strobe
  input  wire logic                 specialMode,      // special (test) mode level
  input  wire logic                 debugActive,      // active background debug mode
  input  wire wpc_tol_s             synthTol,         // lock-detector comparators
  output logic                      watchdogReset,    // one-cycle system reset request
  output logic                      tickCounterHalt,  // freezes periodic tick counter
  output logic                      lockIrq,          // interrupt request level
  output logic                      synthPowerOn,     // synth enable to analog loop
  output logic                      filterAcquire,    // high bandwidth filter select
  output logic                      synthClockSelect, // system clock from synth
  output logic [7:0]                synthMultiplier,  // feedback ratio 2*(mult+1)
  output logic [4:0]                synthRefDivide,   // reference ratio divider+1
  output logic [1:0]                busClockDivide    // bus clock divide of source
);

  // ==========================================================
  // register state
  logic                 windowMode;
  logic                 debugStop;
  logic [RATE_W-1:0]    rateSel;
  logic                 ctlLocked;
  logic                 debugStopLocked;
  logic [LOOP_MULT_W-1:0] loopMult;
  logic [REF_DIV_W-1:0] refDiv;
  logic                 lockIrqEn;
  logic                 autoBw;
  logic                 acqBit;
  logic [7:0]           factoryBypass;
  logic [7:0]           factoryClock;
  logic                 trackFlag;
  logic                 lockFlag;
  logic                 lockChange;
  logic                 armed;
  logic [WD_CNT_W-1:0]  wdCount;

  logic wrCtl;
  logic wrKey;
  logic wrFlags;
  logic wdEnabled;
  logic wdHalted;
  logic [WD_CNT_W-1:0] periodLast;
  logic [WD_CNT_W-1:0] windowStart;
  logic keyEarly;
  logic keyBad;
  logic keyRestart;
  logic timeout;
  logic nextTrack;
  logic nextLock;
  logic [WD_CNT_W-1:0] periodLen;
  logic wrSynthCtl;
  logic nextAutoBw;
  logic nextAcq;

  assign wrCtl   = regWrStb && (regAddr == WATCHDOG_CONTROL_OFS);
  assign wrKey   = regWrStb && (regAddr == SERVICE_KEY_OFS);
  assign wrFlags = regWrStb && (regAddr == CLOCK_UNIT_FLAGS_OFS);
  assign wrSynthCtl = regWrStb && (regAddr == SYNTH_CONTROL_OFS);

  // ==========================================================
  // timeout decode
  function automatic logic [WD_CNT_W-1:0] rate_period(input logic [RATE_W-1:0] r);
    int e;
    e = 0;
    case (r)
      3'h1: e = RATE_LOG2_1;
      3'h2: e = RATE_LOG2_2;
      3'h3: e = RATE_LOG2_3;
      3'h4: e = RATE_LOG2_4;
      3'h5: e = RATE_LOG2_5;
      3'h6: e = RATE_LOG2_6;
      3'h7: e = RATE_LOG2_7;
      default: e = 0;
    endcase
    e = e - RATE_LOG2_TRIM;
    // deep trims clamp at four cycles so the window keeps one cycle
    if (e < WINDOW_QUARTER_LOG2) begin
      e = WINDOW_QUARTER_LOG2;
    end
    return WD_CNT_W'(1) << e;
  endfunction

  // RULE5: rate decode
  assign wdEnabled   = (rateSel != RATE_OFF);
  assign periodLen   = rate_period(rateSel);
  assign periodLast  = periodLen - WD_CNT_W'(1);
  // RULE2: last quarter opens
  assign windowStart = periodLen - (periodLen >> WINDOW_QUARTER_LOG2);

  // RULE4: debug halt of both counters
  assign wdHalted        = debugStop && debugActive;
  // the tick counter sits outside; only its halt is made here
  assign tickCounterHalt = wdHalted;

  // RULE10: no effect while disabled
  assign keyEarly   = wrKey && wdEnabled && windowMode && (wdCount < windowStart);
  // checked in the open window too: only the two keys are legal
  // RULE11: foreign value resets
  assign keyBad     = wrKey && wdEnabled && (regWrData != KEY_FIRST) && (regWrData != KEY_SECOND);
  // RULE20: restart only when armed
  assign keyRestart = wrKey && wdEnabled && !keyEarly && (regWrData == KEY_SECOND) && armed;
  // RULE7: end of period
  assign timeout    = wdEnabled && !wdHalted && (wdCount == periodLast);

  // ==========================================================
  // watchdog control register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      windowMode <= WATCHDOG_CONTROL_RST[WINDOW_MODE_BIT];
      rateSel    <= WATCHDOG_CONTROL_RST[RATE_LSB +: RATE_W];
      ctlLocked  <= 1'b0;
    // RULE1: once in user mode
    end else if (wrCtl && (specialMode || !ctlLocked)) begin
      windowMode <= regWrData[WINDOW_MODE_BIT];
      rateSel    <= regWrData[RATE_LSB +: RATE_W];
      // special-mode writes leave the lock open for the later user setup
      ctlLocked  <= !specialMode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      debugStop       <= WATCHDOG_CONTROL_RST[DEBUG_STOP_BIT];
      debugStopLocked <= 1'b0;
    // RULE1: debug stop once in every mode
    end else if (wrCtl && !debugStopLocked) begin
      debugStop       <= regWrData[DEBUG_STOP_BIT];
      debugStopLocked <= 1'b1;
    end
  end

  // ==========================================================
  // service key sequence
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      armed <= 1'b0;
    // a stale first key must not pair with a later second key
    end else if (!wdEnabled || keyRestart || timeout || keyBad || keyEarly) begin
      armed <= 1'b0;
    // RULE12: repeated first keys keep it armed
    end else if (wrKey && (regWrData == KEY_FIRST)) begin
      armed <= 1'b1;
    end
  end

  // ==========================================================
  // watchdog counter
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wdCount <= '0;
    // RULE6: accepted rate write restarts the period
    end else if (wrCtl && (specialMode || !ctlLocked)) begin
      wdCount <= '0;
    // RULE8: measured from service restart
    // RULE3: restart closes the window again
    end else if (keyRestart || timeout) begin
      wdCount <= '0;
    end else if (wdEnabled && !wdHalted) begin
      wdCount <= wdCount + WD_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      watchdogReset <= 1'b0;
    end else begin
      // a request only: the counter keeps its rate and runs on
      // RULE7: timeout, early or bad key all reset the part
      watchdogReset <= timeout || keyBad || keyEarly;
    end
  end

  // ==========================================================
  // synth control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      loopMult <= '0;
      refDiv   <= '0;
    end else if (regWrStb) begin
      if (regAddr == LOOP_MULTIPLIER_OFS) begin
        loopMult <= regWrData[LOOP_MULT_W-1:0];
      end
      if (regAddr == REFERENCE_DIVIDER_OFS) begin
        refDiv <= regWrData[REF_DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      synthPowerOn <= SYNTH_CONTROL_RST[SYNTH_POWER_BIT];
      autoBw       <= SYNTH_CONTROL_RST[AUTO_BW_BIT];
      acqBit       <= SYNTH_CONTROL_RST[ACQUIRE_BIT];
    end else if (wrSynthCtl) begin
      // synth cannot be switched off while it clocks the system
      if (!synthClockSelect) begin
        synthPowerOn <= regWrData[SYNTH_POWER_BIT];
      end
      autoBw <= regWrData[AUTO_BW_BIT];
      acqBit <= regWrData[ACQUIRE_BIT];
    end
  end

  // RULE19: selection left to software; lock is only reported
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      synthClockSelect <= 1'b0;
      lockIrqEn        <= 1'b0;
    end else if (regWrStb) begin
      if (regAddr == CLOCK_SELECT_OFS) begin
        synthClockSelect <= regWrData[SYNTH_SELECT_BIT];
      end
      if (regAddr == IRQ_ENABLE_OFS) begin
        lockIrqEn <= regWrData[LOCK_IRQ_EN_BIT];
      end
    end
  end

  // RULE13: ratio figures for the analog dividers
  assign synthMultiplier = 8'(SYNTH_MULT_FACTOR * (int'(loopMult) + 1));
  assign synthRefDivide  = 5'(int'(refDiv) + 1);
  // only ratios leave here; the dividers sit in the clock tree
  // RULE14: bus runs at half the synth output
  assign busClockDivide  = synthClockSelect ? 2'(BUS_FROM_SYNTH_DIV) : 2'(1);

  // ==========================================================
  // lock detector
  // RULE15: written values, so the track flag never lags the filter select
  assign nextAutoBw = wrSynthCtl ? regWrData[AUTO_BW_BIT] : autoBw;
  assign nextAcq    = wrSynthCtl ? regWrData[ACQUIRE_BIT] : acqBit;

  always_comb begin
    nextTrack = trackFlag;
    nextLock  = lockFlag;
    if (!synthPowerOn) begin
      nextTrack = 1'b0;
      nextLock  = 1'b0;
    end else begin
      // RULE16: hysteresis between set and clear tolerances
      if (synthTol.inLockTol) begin
        nextLock = 1'b1;
      end else if (synthTol.outLockTol) begin
        nextLock = 1'b0;
      end
      if (nextAutoBw) begin
        if (synthTol.inTrackTol) begin
          nextTrack = 1'b1;
        end else if (synthTol.outTrackTol) begin
          nextTrack = 1'b0;
        end
      end else begin
        // RULE15: manual acquisition keeps tracking clear
        nextTrack = !nextAcq;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trackFlag <= 1'b0;
      lockFlag  <= 1'b0;
    end else begin
      trackFlag <= nextTrack;
      lockFlag  <= nextLock;
    end
  end

  // RULE16: filter follows detector in automatic mode
  // RULE18: manual mode follows the acquire bit
  assign filterAcquire = synthPowerOn && (autoBw ? !trackFlag : acqBit);

  // RULE17: either edge of lock sets the sticky change flag; set beats clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lockChange <= 1'b0;
    end else if (nextLock != lockFlag) begin
      lockChange <= 1'b1;
    end else if (wrFlags && regWrData[LOCK_CHANGE_BIT]) begin
      lockChange <= 1'b0;
    end
  end

  assign lockIrq = lockIrqEn && lockChange;

  // ==========================================================
  // factory test registers
  // stores matter only in special mode; user reads see fixed values
  // RULE9: writable only in special mode
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      factoryBypass <= FACTORY_BYPASS_RST;
      factoryClock  <= FACTORY_CLOCK_RST;
    end else if (regWrStb && specialMode) begin
      if (regAddr == FACTORY_BYPASS_OFS) begin
        factoryBypass <= regWrData;
      end
      if (regAddr == FACTORY_CLOCK_OFS) begin
        factoryClock <= regWrData;
      end
    end
  end

  // ==========================================================
  // read port
  // reads have no side effects; the change flag clears only by write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      regRdData <= UNMAPPED_READ;
    end else if (regRdStb) begin
      regRdData <= UNMAPPED_READ;
      case (regAddr)
        LOOP_MULTIPLIER_OFS:   regRdData <= 8'(loopMult);
        REFERENCE_DIVIDER_OFS: regRdData <= 8'(refDiv);
        CLOCK_UNIT_FLAGS_OFS: begin
          regRdData[LOCK_CHANGE_BIT] <= lockChange;
          regRdData[LOCK_BIT]        <= lockFlag;
          regRdData[TRACK_BIT]       <= trackFlag;
        end
        IRQ_ENABLE_OFS:        regRdData[LOCK_IRQ_EN_BIT] <= lockIrqEn;
        CLOCK_SELECT_OFS:      regRdData[SYNTH_SELECT_BIT] <= synthClockSelect;
        SYNTH_CONTROL_OFS: begin
          regRdData[SYNTH_POWER_BIT] <= synthPowerOn;
          regRdData[AUTO_BW_BIT]     <= autoBw;
          regRdData[ACQUIRE_BIT]     <= acqBit;
        end
        WATCHDOG_CONTROL_OFS: begin
          regRdData[WINDOW_MODE_BIT]         <= windowMode;
          regRdData[DEBUG_STOP_BIT]          <= debugStop;
          regRdData[RATE_LSB +: RATE_W]      <= rateSel;
        end
        // RULE9: fixed values outside special mode
        FACTORY_BYPASS_OFS: regRdData <= specialMode ? factoryBypass : FACTORY_BYPASS_READ;
        FACTORY_CLOCK_OFS:  regRdData <= specialMode ? factoryClock : FACTORY_CLOCK_READ;
        // RULE10: key register always reads zero
        SERVICE_KEY_OFS:    regRdData <= 8'h00;
        default:            regRdData <= UNMAPPED_READ;
      endcase
    end
  end

endmodule

// file: hw/wpc_pkg.sv
package wpc_pkg;

  // ==========================================================
  // register offsets, index on the 4-bit register port
  localparam logic [3:0] LOOP_MULTIPLIER_OFS  = 4'h0;
  localparam logic [3:0] REFERENCE_DIVIDER_OFS = 4'h1;
  localparam logic [3:0] CLOCK_UNIT_FLAGS_OFS = 4'h3;
  localparam logic [3:0] IRQ_ENABLE_OFS       = 4'h4;
  localparam logic [3:0] CLOCK_SELECT_OFS     = 4'h5;
  localparam logic [3:0] SYNTH_CONTROL_OFS    = 4'h6;
  localparam logic [3:0] WATCHDOG_CONTROL_OFS = 4'h8;
  localparam logic [3:0] FACTORY_BYPASS_OFS   = 4'h9;
  localparam logic [3:0] FACTORY_CLOCK_OFS    = 4'ha;
  localparam logic [3:0] SERVICE_KEY_OFS      = 4'hb;

  // ==========================================================
  // field positions
  localparam int WINDOW_MODE_BIT   = 7;
  localparam int DEBUG_STOP_BIT    = 6;
  localparam int RATE_LSB          = 0;
  localparam int LOOP_MULT_W       = 6;
  localparam int REF_DIV_W         = 4;
  localparam int LOCK_CHANGE_BIT   = 4;
  localparam int LOCK_BIT          = 3;
  localparam int TRACK_BIT         = 2;
  localparam int LOCK_IRQ_EN_BIT   = 4;
  localparam int SYNTH_SELECT_BIT  = 7;
  localparam int SYNTH_POWER_BIT   = 6;
  localparam int AUTO_BW_BIT       = 5;
  localparam int ACQUIRE_BIT       = 4;

  // ==========================================================
  // reset and fixed values
  localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h00;
  localparam logic [7:0] SYNTH_CONTROL_RST    = 8'h30;
  localparam logic [7:0] FACTORY_BYPASS_RST   = 8'h00;
  localparam logic [7:0] FACTORY_CLOCK_RST    = 8'h80;
  localparam logic [7:0] FACTORY_BYPASS_READ  = 8'h00;
  localparam logic [7:0] FACTORY_CLOCK_READ   = 8'h80;
  localparam logic [7:0] KEY_FIRST            = 8'h55;
  localparam logic [7:0] KEY_SECOND           = 8'haa;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;

  // ==========================================================
  // watchdog timing: log2 of oscillator cycles per rate code
  localparam int RATE_W     = 3;
  localparam int WD_CNT_W   = 25;
  localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;
  localparam int RATE_LOG2_1 = 14;
  localparam int RATE_LOG2_2 = 16;
  localparam int RATE_LOG2_3 = 18;
  localparam int RATE_LOG2_4 = 20;
  localparam int RATE_LOG2_5 = 22;
  localparam int RATE_LOG2_6 = 23;
  localparam int RATE_LOG2_7 = 24;
  // open window is the last quarter: shift by two
  localparam int WINDOW_QUARTER_LOG2 = 2;
  localparam int BUS_FROM_SYNTH_DIV  = 2;
  localparam int SYNTH_MULT_FACTOR   = 2;

  // ==========================================================
  // lock-detector comparator levels from the analog loop
  typedef struct packed {
    logic inTrackTol;
    logic outTrackTol;
    logic inLockTol;
    logic outLockTol;
  } wpc_tol_s;

endpackage

// file: sim/wpc_watchdog_pll_asserts.sv
`timescale 1ns/100ps
module wpc_watchdog_pll_asserts
  import wpc_pkg::*;
(
  input wire logic       sys_clk,          // oscillator clock
  input wire logic       rst_b,            // sync reset, low
  input wire logic [3:0] regAddr,          // register index
  input wire logic [7:0] regWrData,        // write data
  input wire logic       regWrStb,         // write strobe
  input wire logic       regRdStb,         // read strobe
  input wire logic [7:0] regRdData,        // read data
  input wire logic       specialMode,      // special mode
  input wire logic       debugActive,      // active debug
  input wire logic       watchdogReset,    // reset request
  input wire logic       tickCounterHalt,  // tick halt
  input wire logic       filterAcquire,    // filter select
  input wire logic       synthClockSelect, // synth selected
  input wire logic [4:0] synthRefDivide,   // reference ratio
  input wire logic [1:0] busClockDivide    // bus divide
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // shadow of the rate field, so key checks know enable state
  logic [2:0] rate;
  logic       userLocked;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rate       <= 3'h0;
      userLocked <= 1'b0;
    end else if (regWrStb && regAddr == WATCHDOG_CONTROL_OFS && (specialMode || !userLocked)) begin
      rate       <= regWrData[2:0];
      userLocked <= !specialMode;
    end
  end

  // ==========================================================
  key_bad_a: assert property (regWrStb && regAddr == SERVICE_KEY_OFS && rate != 3'h0 &&
    regWrData != KEY_FIRST && regWrData != KEY_SECOND |=> watchdogReset)
    else $error("bad service key gave no reset");
  key_off_a: assert property (regWrStb && regAddr == SERVICE_KEY_OFS && rate == 3'h0 |=> !watchdogReset)
    else $error("key write while disabled gave reset");
  key_read_a: assert property (regRdStb && regAddr == SERVICE_KEY_OFS |=> regRdData == 8'h00)
    else $error("service key read not zero");
  bypass_read_a: assert property (regRdStb && regAddr == FACTORY_BYPASS_OFS && !specialMode
    |=> regRdData == 8'h00)
    else $error("bypass test register read wrong");
  clock_read_a: assert property (regRdStb && regAddr == FACTORY_CLOCK_OFS && !specialMode
    |=> regRdData == 8'h80)
    else $error("clock test register read wrong");
  unmapped_read_a: assert property (regRdStb && regAddr >= 4'hc |=> regRdData == UNMAPPED_READ)
    else $error("unmapped read not zero");
  bus_divide_a: assert property (busClockDivide == (synthClockSelect ? 2'h2 : 2'h1))
    else $error("bus divide does not follow clock select");
  ref_range_a: assert property (synthRefDivide >= 5'h01 && synthRefDivide <= 5'h10)
    else $error("reference divide out of range");
  halt_debug_a: assert property (!debugActive |-> !tickCounterHalt)
    else $error("tick halted outside debug");
  track_acquire_a: assert property (regRdStb && regAddr == CLOCK_UNIT_FLAGS_OFS && filterAcquire
    |=> !regRdData[TRACK_BIT])
    else $error("track flag set during acquisition");
endmodule

bind wpc_watchdog_pll wpc_watchdog_pll_asserts i_wpc_watchdog_pll_asserts (
  .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .specialMode(specialMode), .debugActive(debugActive),
  .watchdogReset(watchdogReset), .tickCounterHalt(tickCounterHalt), .filterAcquire(filterAcquire),
  .synthClockSelect(synthClockSelect), .synthRefDivide(synthRefDivide), .busClockDivide(busClockDivide)
);

// file: sim/tb_watchdog_pll_control.sv
`timescale 1ns/100ps
module tb_watchdog_pll_control;
  import wpc_pkg::*;
  // trims every exponent: rate 1 lasts 16 cycles
  localparam int TRIM = 10;
  logic       sys_clk, rst_b, regWrStb, regRdStb, specialMode, debugActive;
  logic       watchdogReset, tickCounterHalt, lockIrq, synthPowerOn, filterAcquire, synthClockSelect;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, synthMultiplier;
  logic [4:0] synthRefDivide;
  logic [1:0] busClockDivide;
  wpc_tol_s   synthTol;
  int         fails, compares, pulses;

  wpc_watchdog_pll #(.RATE_LOG2_TRIM(TRIM)) i_wpc_watchdog_pll (
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .specialMode(specialMode), .debugActive(debugActive),
    .synthTol(synthTol), .watchdogReset(watchdogReset), .tickCounterHalt(tickCounterHalt),
    .lockIrq(lockIrq), .synthPowerOn(synthPowerOn), .filterAcquire(filterAcquire),
    .synthClockSelect(synthClockSelect), .synthMultiplier(synthMultiplier),
    .synthRefDivide(synthRefDivide), .busClockDivide(busClockDivide));

  // ==========================================================
  // shared helpers
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // reset pulses stand one cycle, so count them at the settled falling edge
  always @(negedge sys_clk) if (watchdogReset === 1'b1) pulses++;
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // the gap cycle keeps back-to-back calls from driving a strobe twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a; regWrData <= d; regWrStb <= 1'b1;
    @(posedge sys_clk); regWrStb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    regAddr <= a; regRdStb <= 1'b1;
    @(posedge sys_clk); regRdStb <= 1'b0;
    #1 check(nm, e, regRdData);
    @(posedge sys_clk);
  endtask
  // n = cycles until the reset pulse, maxc if none came
  task automatic waitRst(input int maxc, output int n);
    for (n = 0; n < maxc; n++) begin
      #1;
      if (watchdogReset === 1'b1) break;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic regsAfterReset();
    rd(WATCHDOG_CONTROL_OFS, WATCHDOG_CONTROL_RST, "control reset");
    rd(SYNTH_CONTROL_OFS, SYNTH_CONTROL_RST, "synth control reset");
    wr(FACTORY_BYPASS_OFS, 8'hff);
    wr(FACTORY_CLOCK_OFS, 8'h00);
    rd(FACTORY_BYPASS_OFS, 8'h00, "bypass test");
    rd(FACTORY_CLOCK_OFS, 8'h80, "clock test");
    rd(SERVICE_KEY_OFS, 8'h00, "service key read");
    rd(4'hf, UNMAPPED_READ, "unmapped");
    check("bus divide oscillator", 2'h1, busClockDivide);
  endtask
  task automatic rateTimeouts();
    int n, p;
    int lg [1:7] = '{RATE_LOG2_1, RATE_LOG2_2, RATE_LOG2_3, RATE_LOG2_4, RATE_LOG2_5, RATE_LOG2_6, RATE_LOG2_7};
    specialMode <= 1'b1;
    for (int r = 1; r < 8; r++) begin
      p = 1 << (lg[r] - TRIM);
      wr(WATCHDOG_CONTROL_OFS, 8'(r));
      waitRst(p + 8, n);
      check("timeout period", p - 1, n);
    end
    wr(WATCHDOG_CONTROL_OFS, 8'h00);
    n = pulses;
    wr(SERVICE_KEY_OFS, 8'h13);
    tick(40);
    check("key while disabled", n, pulses);
  endtask
  task automatic serviceKeys();
    int n;
    wr(WATCHDOG_CONTROL_OFS, 8'h02);
    tick(30);
    wr(SERVICE_KEY_OFS, KEY_FIRST);
    rd(CLOCK_SELECT_OFS, 8'h00, "access between keys");
    wr(SERVICE_KEY_OFS, KEY_FIRST);
    wr(SERVICE_KEY_OFS, KEY_SECOND);
    tick(20);
    wr(SERVICE_KEY_OFS, KEY_SECOND);
    wr(SERVICE_KEY_OFS, KEY_SECOND);
    waitRst(80, n);
    check("period from restart", 1, n >= 37 && n <= 41);
    n = pulses;
    wr(SERVICE_KEY_OFS, 8'h12);
    check("bad key reset", n + 1, pulses);
  endtask
  task automatic windowMode();
    int n;
    wr(WATCHDOG_CONTROL_OFS, 8'h82);
    n = pulses;
    wr(SERVICE_KEY_OFS, KEY_FIRST);
    check("early key reset", n + 1, pulses);
    wr(WATCHDOG_CONTROL_OFS, 8'h82);
    tick(52);
    n = pulses;
    wr(SERVICE_KEY_OFS, KEY_FIRST);
    wr(SERVICE_KEY_OFS, KEY_FIRST);
    wr(SERVICE_KEY_OFS, KEY_SECOND);
    check("keys in open window", n, pulses);
    wr(SERVICE_KEY_OFS, KEY_FIRST);
    check("window closed after restart", n + 1, pulses);
    wr(WATCHDOG_CONTROL_OFS, 8'h00);
  endtask
  task automatic synthLock();
    wr(LOOP_MULTIPLIER_OFS, 8'h05);
    wr(REFERENCE_DIVIDER_OFS, 8'h0f);
    check("multiplier", 8'h0c, synthMultiplier);
    check("reference divide", 5'h10, synthRefDivide);
    wr(SYNTH_CONTROL_OFS, 8'h60);
    wr(IRQ_ENABLE_OFS, 8'h10);
    synthTol <= 4'b1010;
    tick(3);
    check("filter tracking", 0, filterAcquire);
    check("lock irq on lock", 1, lockIrq);
    rd(CLOCK_UNIT_FLAGS_OFS, 8'h1c, "flags locked");
    wr(CLOCK_UNIT_FLAGS_OFS, 8'h10);
    check("lock irq cleared", 0, lockIrq);
    wr(CLOCK_SELECT_OFS, 8'h80);
    check("bus divide synth", 2'h2, busClockDivide);
    synthTol <= 4'b0101;
    tick(3);
    check("lock irq on loss", 1, lockIrq);
    check("filter acquiring", 1, filterAcquire);
    rd(CLOCK_UNIT_FLAGS_OFS, 8'h10, "flags lost");
  endtask
  task automatic writeOnceDebug();
    int n;
    specialMode <= 1'b0;
    rst_b <= 1'b0;
    tick(3);
    rst_b <= 1'b1;
    tick(1);
    wr(WATCHDOG_CONTROL_OFS, 8'h41);
    wr(WATCHDOG_CONTROL_OFS, 8'h80);
    rd(WATCHDOG_CONTROL_OFS, 8'h41, "control locked");
    debugActive <= 1'b1;
    tick(1);
    check("tick halt", 1, tickCounterHalt);
    waitRst(40, n);
    check("halted in debug", 40, n);
    debugActive <= 1'b0;
    waitRst(24, n);
    check("resumes after debug", 1, n < 20);
  endtask
  task automatic manualBandwidth();
    wr(SYNTH_CONTROL_OFS, 8'h50);
    check("synth power", 1, synthPowerOn);
    check("manual acquire", 1, filterAcquire);
    rd(CLOCK_UNIT_FLAGS_OFS, 8'h00, "flags acquiring");
    wr(SYNTH_CONTROL_OFS, 8'h40);
    check("manual tracking", 0, filterAcquire);
    rd(CLOCK_UNIT_FLAGS_OFS, 8'h04, "flags tracking");
  endtask

  // ==========================================================
  initial begin
    {rst_b, regWrStb, regRdStb, specialMode, debugActive} = 5'h00;
    regAddr = 4'h0;
    regWrData = 8'h00;
    synthTol = 4'h0;
    fails = 0;
    compares = 0;
    tick(20);
    rst_b <= 1'b1;
    tick(1);
    regsAfterReset();
    rateTimeouts();
    serviceKeys();
    windowMode();
    synthLock();
    writeOnceDebug();
    manualBandwidth();
    complete_run();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
endmodule
